// [logic/clk_ctrl_pkg.sv]
// Shared constants, register map and carrier types for the clock control block
package clk_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register offsets (word addresses on the internal register port)
  // ----------------------------------------------------------------
  localparam logic [6:0] MAIN_PATH_MODE_DIVIDE_ADDR = 7'h19;  // Mode and divide
  localparam logic [6:0] OUT_CTRL_ADDR              = 7'h1A;  // Output enables, divider reset
  localparam logic [6:0] AUX_CFG_ADDR               = 7'h1B;  // Aux format, level, prediv
  localparam logic [6:0] AUX_POSTDIV_ADDR           = 7'h1C;  // Aux post-divide ratio
  localparam logic [6:0] ALIGN_CFG_ADDR             = 7'h1D;  // Align bias and delay
  localparam logic [6:0] ALIGN_POS_ADDR             = 7'h1E;  // Edge position readback

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int          MODE_LSB        = 0;      // Mode field 2:0
  localparam int          DIV_LSB         = 3;      // Divide field 5:3
  localparam logic [2:0]  MODE_BUFFER     = 3'h1;   // Buffer mode code
  localparam logic [2:0]  MODE_DIVIDER    = 3'h2;   // Divider mode code
  localparam logic [1:0]  FMT_LVDS        = 2'h0;   // Aux format LVDS
  localparam logic [1:0]  FMT_CML         = 2'h2;   // Aux format CML
  localparam logic [1:0]  BIAS_DC         = 2'h3;   // Align input unbiased
  localparam int          DIV_RST_BIT     = 4;      // Main divider reset bit in OUT_CTRL

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] MAIN_PATH_RST   = 16'h0001;  // Buffer mode, all bypassed
  localparam logic [15:0] OUT_CTRL_RST    = 16'h000F;  // All register enables on
  localparam logic [15:0] AUX_CFG_RST     = 16'h0000;  // LVDS, prediv 1
  localparam logic [15:0] AUX_POSTDIV_RST = 16'h0001;  // Post-divide bypass
  localparam logic [15:0] ALIGN_CFG_RST   = 16'h0000;  // Bias 1.3 V, no delay

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS  = 8000;  // Input clock period
  localparam int ALIGN_EXTRA_PS = 1600;  // Extra high time beyond three periods
  localparam int ALIGN_HOLD_CYC = 3 + (ALIGN_EXTRA_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DELAY_DEPTH    = 64;    // Alignment delay taps

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       lvds_sel;      // LVDS signalling active
    logic       cml_sel;       // CML signalling active
    logic [2:0] common_mode;   // Common-mode code, valid in LVDS
    logic [2:0] power_level;   // Swing code, valid in CML
  } aux_drive_t;

  typedef struct packed {
    logic       divider_mode;  // 1: main path divides
    logic [3:0] ratio;         // Effective main ratio (1 in buffer mode)
    logic [3:0] out_en;        // Effective per-channel enables
  } main_state_t;

endpackage

// [logic/ratio_divider.sv]
// Counting divider with synchronous clear, driven by an input tick enable
module ratio_divider (
  input  wire logic       clk,        // Input clock
  input  wire logic       rst_b,      // Async reset, active low
  input  wire logic       clr,        // Synchronous phase clear
  input  wire logic       tick_in,    // Incoming rate enable
  input  wire logic [9:0] ratio,      // Divide ratio, 0 treated as 1
  output logic            tick_out,   // One pulse per output period
  output logic            level_out   // Divided phase level
);
  logic [9:0] count_q;  // Phase counter
  logic [9:0] count_d;  // Next phase
  logic [9:0] r_eff;    // Ratio with zero mapped to bypass
  logic       wrap;     // Last phase of a period

  assign r_eff    = (ratio == 10'h000) ? 10'h001 : ratio;
  // Compare with >= so a ratio lowered under the running count wraps at once
  assign wrap     = (count_q >= r_eff - 10'h001);
  assign tick_out = tick_in & wrap;
  // Low time is the longer half, so odd ratios are not balanced
  assign level_out = (r_eff == 10'h001) ? tick_in : (count_q < (r_eff >> 1));
  assign count_d  = clr ? 10'h000 : (tick_in ? (wrap ? 10'h000 : count_q + 10'h001) : count_q);

  // ----------------------------------------------------------------
  // Phase counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= 10'h000;
    end else begin
      count_q <= count_d;
    end
  end
endmodule

// [logic/divider_align_pin_mode_control.sv]
// Main and aux divider control with pin mode and alignment windowing
module divider_align_pin_mode_control
  import clk_ctrl_pkg::*;
(
  input  wire logic                     SYS_CLK,              // Input clock
  input  wire logic                     RST_B,                // Async reset, active low
  input  wire logic                     REG_WE,               // Register write strobe
  input  wire logic [6:0]               REG_ADDR,             // Register address
  input  wire logic [15:0]              REG_WDATA,            // Register write data
  output logic      [15:0]              REG_RDATA,            // Register read data
  input  wire logic [2:0]               OUT_ENABLE_PIN,       // Enable pins: ch0, ch1, ch2+3
  input  wire logic                     MODE_SELECT_PIN,      // Mode pin
  input  wire logic                     RATIO_SELECT_PIN_LO,  // Ratio pin low
  input  wire logic                     RATIO_SELECT_PIN_HI,  // Ratio pin high
  input  wire logic                     ALIGN_IN,             // Alignment pin
  output clk_ctrl_pkg::main_state_t     MAIN_STATE,           // Effective main path state
  output logic      [3:0]               MAIN_OUT,             // Gated divided main phases
  output logic                          AUX_OUTPUT,           // Aux divided phase
  output clk_ctrl_pkg::aux_drive_t      AUX_DRIVE,            // Aux driver selection
  output logic      [1:0]               ALIGN_INPUT_BIAS,     // Alignment input bias code
  output logic      [1:0]               ALIGN_DELAY_UNIT      // Delay step code
);
  import clk_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] main_q;      // Mode and divide
  logic [15:0] outc_q;      // Register enables and divider reset
  logic [15:0] auxc_q;      // Aux configuration
  logic [15:0] auxp_q;      // Aux post ratio
  logic [15:0] algc_q;      // Alignment configuration
  logic [15:0] pos_q;       // Edge position capture, bit 15 valid
  logic [15:0] pos_d;       // Next capture

  // ----------------------------------------------------------------
  // Pin synchronisers: three stages, accept when last two agree
  // ----------------------------------------------------------------
  localparam int NPIN = 7;  // Enables, mode, ratio lo/hi, align
  logic [NPIN-1:0] pin_raw;  // Raw pins
  logic [NPIN-1:0] pin_s1;   // First stage, read only by pin_s2
  logic [NPIN-1:0] pin_s2;   // Second stage
  logic [NPIN-1:0] pin_s3;   // Third stage
  logic [NPIN-1:0] pin_f;    // Filtered pin levels

  assign pin_raw = {ALIGN_IN, RATIO_SELECT_PIN_HI, RATIO_SELECT_PIN_LO, MODE_SELECT_PIN, OUT_ENABLE_PIN};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      // Per-pin synchroniser and agreement filter
      always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
          pin_s1[gi] <= 1'b0;
          pin_s2[gi] <= 1'b0;
          pin_s3[gi] <= 1'b0;
          pin_f[gi]  <= 1'b0;
        end else begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
          pin_s3[gi] <= pin_s2[gi];
          if (pin_s2[gi] == pin_s3[gi]) begin
            pin_f[gi] <= pin_s3[gi];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Pin mode resolution
  // ----------------------------------------------------------------
  wire [2:0] en_pin    = pin_f[2:0];
  wire       mode_pin  = pin_f[3];
  wire [1:0] ratio_pin = pin_f[5:4];
  wire       align_f   = pin_f[6];
  wire [2:0] mode_fld  = main_q[MODE_LSB +: 3];
  wire [2:0] div_fld   = main_q[DIV_LSB +: 3];

  wire       div_mode  = mode_pin | (mode_fld == MODE_DIVIDER);
  // code plus one, reserved as 2
  wire [3:0] reg_ratio = (div_fld == 3'h0) ? 4'h2 : {1'b0, div_fld} + 4'h1;
  wire [3:0] pin_ratio = {2'b00, ratio_pin} + 4'h1;
  wire [3:0] main_ratio = !div_mode ? 4'h1 : ((ratio_pin == 2'b00) ? reg_ratio : pin_ratio);
  // channels 2 and 3 share a pin
  wire [3:0] en_pins   = {en_pin[2], en_pin[2], en_pin[1], en_pin[0]};
  // pin low forces off, else register
  wire [3:0] out_en    = en_pins & outc_q[3:0];

  // ----------------------------------------------------------------
  // Aux configuration decode
  // ----------------------------------------------------------------
  wire [1:0] fmt       = auxc_q[1:0];
  wire [1:0] pre_code  = auxc_q[9:8];    // 0:1, 1:2, 2:4
  wire [1:0] band      = auxc_q[11:10];  // 0: <=3.2, 1: <=6.4, else above
  // raise prediv to the least allowed in band
  wire [1:0] pre_req   = (pre_code > 2'h2) ? 2'h2 : pre_code;
  wire [1:0] pre_min   = (band == 2'h0) ? 2'h0 : ((band == 2'h1) ? 2'h1 : 2'h2);
  wire [1:0] pre_eff   = (pre_req < pre_min) ? pre_min : pre_req;
  wire [9:0] pre_ratio = 10'h001 << pre_eff;

  // format selects driver and its setting
  assign AUX_DRIVE.lvds_sel    = (fmt == FMT_LVDS);
  assign AUX_DRIVE.cml_sel     = (fmt == FMT_CML);
  assign AUX_DRIVE.common_mode = (fmt == FMT_LVDS) ? auxc_q[4:2] : 3'h0;
  assign AUX_DRIVE.power_level = (fmt == FMT_CML) ? auxc_q[7:5] : 3'h0;

  // bias code passed to the input stage
  assign ALIGN_INPUT_BIAS = algc_q[1:0];
  // step code chosen by software per input rate
  assign ALIGN_DELAY_UNIT = algc_q[3:2];
  wire [5:0] taps = algc_q[9:4];

  // ----------------------------------------------------------------
  // Alignment delay line and edge detect
  // ----------------------------------------------------------------
  logic [DELAY_DEPTH-1:0] dly_q;     // Delay line of the filtered pin
  logic                   dly_prev_q; // Last delayed level
  logic                   align_q;   // One-cycle clear pulse
  logic                   f_prev_q;  // Last filtered level
  logic [3:0]             hold_q;    // High-time counter for capture

  // tapped delay of the alignment level
  wire dly_tap  = dly_q[taps];
  // single rising edge after retiming and delay
  wire dly_rise = dly_tap & ~dly_prev_q;
  wire f_rise   = align_f & ~f_prev_q;

  // capture only after the minimum high time
  wire hold_done = align_f && (hold_q == 4'(ALIGN_HOLD_CYC));
  // window of delayed levels around the edge
  assign pos_d = f_rise ? 16'h0000 : (hold_done ? {1'b1, dly_q[14:0]} : pos_q);

  // Delay line, edge detect and capture
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      dly_q      <= '0;
      dly_prev_q <= 1'b0;
      align_q    <= 1'b0;
      f_prev_q   <= 1'b0;
      hold_q     <= 4'h0;
      pos_q      <= 16'h0000;
    end else begin
      dly_q      <= {dly_q[DELAY_DEPTH-2:0], align_f};
      dly_prev_q <= dly_tap;
      // only the pin path drives the clear
      align_q    <= dly_rise;
      f_prev_q   <= align_f;
      // Saturate one past the capture count so the snapshot is taken once per pulse
      hold_q     <= !align_f ? 4'h0 : ((hold_q > 4'(ALIGN_HOLD_CYC)) ? hold_q : hold_q + 4'h1);
      pos_q      <= pos_d;
    end
  end

  // ----------------------------------------------------------------
  // Dividers, all cleared on the same edge
  // ----------------------------------------------------------------
  logic main_lvl;  // Main divided phase
  logic pre_tick;  // Aux prediv output rate
  logic aux_lvl;   // Aux divided phase
  logic pre_lvl;   // Aux prediv divided phase

  // post bypass passes the balanced prediv phase
  wire  post_bypass = (auxp_q[9:0] <= 10'h001);

  // register bit holds the main divider
  wire main_clr = align_q | outc_q[DIV_RST_BIT];

  ratio_divider u_main (
    .clk       (SYS_CLK),
    .rst_b     (RST_B),
    .clr       (main_clr),
    .tick_in   (1'b1),
    .ratio     ({6'h00, main_ratio}),
    .tick_out  (),
    .level_out (main_lvl)
  );

  ratio_divider u_aux_pre (
    .clk       (SYS_CLK),
    .rst_b     (RST_B),
    .clr       (align_q),
    .tick_in   (1'b1),
    .ratio     (pre_ratio),
    .tick_out  (pre_tick),
    .level_out (pre_lvl)
  );

  ratio_divider u_aux_post (
    .clk       (SYS_CLK),
    .rst_b     (RST_B),
    .clr       (align_q),
    .tick_in   (pre_tick),
    .ratio     (auxp_q[9:0]),
    .tick_out  (),
    .level_out (aux_lvl)
  );

  // ----------------------------------------------------------------
  // Outputs from flip-flops
  // ----------------------------------------------------------------
  // Registered so outputs never glitch on pin changes
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      MAIN_STATE <= '0;
      MAIN_OUT   <= 4'h0;
      AUX_OUTPUT <= 1'b0;
    end else begin
      MAIN_STATE <= '{divider_mode: div_mode, ratio: main_ratio, out_en: out_en};
      MAIN_OUT   <= {4{main_lvl}} & out_en;
      AUX_OUTPUT <= post_bypass ? pre_lvl : aux_lvl;
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  wire we_main = REG_WE && (REG_ADDR == MAIN_PATH_MODE_DIVIDE_ADDR);
  wire we_outc = REG_WE && (REG_ADDR == OUT_CTRL_ADDR);
  wire we_auxc = REG_WE && (REG_ADDR == AUX_CFG_ADDR);
  wire we_auxp = REG_WE && (REG_ADDR == AUX_POSTDIV_ADDR);
  wire we_algc = REG_WE && (REG_ADDR == ALIGN_CFG_ADDR);

  // Write decode; the position register has no write effect
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      main_q <= MAIN_PATH_RST;
      outc_q <= OUT_CTRL_RST;
      auxc_q <= AUX_CFG_RST;
      auxp_q <= AUX_POSTDIV_RST;
      algc_q <= ALIGN_CFG_RST;
    end else begin
      if (we_main) main_q <= REG_WDATA;
      if (we_outc) outc_q <= REG_WDATA;
      if (we_auxc) auxc_q <= REG_WDATA;
      if (we_auxp) auxp_q <= REG_WDATA;
      if (we_algc) algc_q <= REG_WDATA;
    end
  end

  // Readback of the mode register reports effective state, as pins may override it
  wire [15:0] main_rd = {main_q[15:6], (div_mode ? main_ratio[2:0] - 3'h1 : div_fld),
                         (div_mode ? MODE_DIVIDER : MODE_BUFFER)};
  assign REG_RDATA = (REG_ADDR == MAIN_PATH_MODE_DIVIDE_ADDR) ? main_rd :
                     (REG_ADDR == OUT_CTRL_ADDR)              ? outc_q  :
                     (REG_ADDR == AUX_CFG_ADDR)               ? auxc_q  :
                     (REG_ADDR == AUX_POSTDIV_ADDR)           ? auxp_q  :
                     (REG_ADDR == ALIGN_CFG_ADDR)             ? algc_q  :
                     (REG_ADDR == ALIGN_POS_ADDR)             ? pos_q   : 16'h0000;
endmodule

// [tb/align_pin_driver.sv]
// Board-side model that drives the alignment pin
module align_pin_driver #(
  parameter int HIGH_CYC = 8,   // Pulse high time in clocks
  parameter int GAP_CYC  = 76   // Rise-to-rise spacing less one, in clocks
) (
  input  wire logic clk,        // Input clock
  input  wire logic rst_b,      // Async reset, active low
  input  wire logic fire,       // Request one pulse
  output logic      align_out   // Alignment pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  int gap_q;  // Clocks until the next rise is allowed
  int hi_q;   // Clocks of high time left
  // idle low, edge-locked rise, long high, spaced
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      align_out <= 1'b0;
      gap_q     <= 0;
      hi_q      <= 0;
    end else begin
      // Spacing counter runs on its own so a held request waits
      if (gap_q != 0) gap_q <= gap_q - 1;
      if (hi_q != 0) begin
        hi_q      <= hi_q - 1;
        align_out <= (hi_q != 1);
      end else if (fire && gap_q == 0) begin
        align_out <= 1'b1;
        hi_q      <= HIGH_CYC;
        gap_q     <= GAP_CYC;
      end
    end
  end
endmodule

// [tb/divider_align_pin_mode_control_properties.sv]
// Port checker for the clock control block
module divider_align_pin_mode_control_properties
  import clk_ctrl_pkg::*;
(
  input wire logic                      SYS_CLK,              // Clock
  input wire logic                      RST_B,                // Reset
  input wire logic                      REG_WE,               // Write strobe
  input wire logic [6:0]                REG_ADDR,             // Address
  input wire logic [15:0]               REG_WDATA,            // Write data
  input wire logic [15:0]               REG_RDATA,            // Read data
  input wire logic [2:0]                OUT_ENABLE_PIN,       // Enable pins
  input wire logic                      MODE_SELECT_PIN,      // Mode pin
  input wire logic                      RATIO_SELECT_PIN_LO,  // Ratio pin low
  input wire logic                      RATIO_SELECT_PIN_HI,  // Ratio pin high
  input wire logic                      ALIGN_IN,             // Alignment pin
  input wire clk_ctrl_pkg::main_state_t MAIN_STATE,           // Main state
  input wire logic [3:0]                MAIN_OUT,             // Main phases
  input wire logic                      AUX_OUTPUT,           // Aux phase
  input wire clk_ctrl_pkg::aux_drive_t  AUX_DRIVE,            // Aux driver
  input wire logic [1:0]                ALIGN_INPUT_BIAS,     // Bias code
  input wire logic [1:0]                ALIGN_DELAY_UNIT      // Step code
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  a_fmt_one_hot: assert property (!(AUX_DRIVE.lvds_sel && AUX_DRIVE.cml_sel))
    else $error("aux format drives both kinds");
  a_cml_level: assert property (REG_ADDR == AUX_CFG_ADDR && REG_RDATA[1:0] == FMT_CML |->
    AUX_DRIVE.cml_sel && AUX_DRIVE.power_level == REG_RDATA[7:5]) else $error("cml level wrong");
  a_lvds_vcm: assert property (REG_ADDR == AUX_CFG_ADDR && REG_RDATA[1:0] == FMT_LVDS |->
    AUX_DRIVE.lvds_sel && AUX_DRIVE.common_mode == REG_RDATA[4:2]) else $error("lvds vcm wrong");
  a_bias_step: assert property (REG_ADDR == ALIGN_CFG_ADDR |->
    {ALIGN_DELAY_UNIT, ALIGN_INPUT_BIAS} == REG_RDATA[3:0]) else $error("bias or step wrong");
  a_post_written: assert property (REG_WE && REG_ADDR == AUX_POSTDIV_ADDR ##1 REG_ADDR == AUX_POSTDIV_ADDR
    |-> REG_RDATA[9:0] == $past(REG_WDATA[9:0])) else $error("post ratio not stored");
  a_ratio_span: assert property (MAIN_STATE.divider_mode |-> MAIN_STATE.ratio inside {[2:8]})
    else $error("divide ratio out of range");
  a_mode_pin_force: assert property (MODE_SELECT_PIN [*6] |=> MAIN_STATE.divider_mode)
    else $error("mode pin did not force divider");
  a_ratio_pin_four: assert property ((MODE_SELECT_PIN && RATIO_SELECT_PIN_HI && RATIO_SELECT_PIN_LO) [*6]
    |=> MAIN_STATE.ratio == 4'h4) else $error("ratio pins did not give four");
  a_shared_enable: assert property (!OUT_ENABLE_PIN[2] [*6] |=> MAIN_STATE.out_en[3:2] == 2'h0)
    else $error("shared enable pin ignored");
  a_pin_gates_out: assert property ((MAIN_OUT & ~MAIN_STATE.out_en & ~$past(MAIN_STATE.out_en)) == 4'h0)
    else $error("disabled channel toggles");
  c_div_eight: cover property (MAIN_STATE.divider_mode && MAIN_STATE.ratio == 4'h8);
  c_align_rise: cover property ($rose(ALIGN_IN));
  c_cml_mode: cover property (AUX_DRIVE.cml_sel);
endmodule

bind divider_align_pin_mode_control divider_align_pin_mode_control_properties u_props (
  .SYS_CLK(SYS_CLK), .RST_B(RST_B), .REG_WE(REG_WE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_RDATA(REG_RDATA), .OUT_ENABLE_PIN(OUT_ENABLE_PIN), .MODE_SELECT_PIN(MODE_SELECT_PIN),
  .RATIO_SELECT_PIN_LO(RATIO_SELECT_PIN_LO), .RATIO_SELECT_PIN_HI(RATIO_SELECT_PIN_HI), .ALIGN_IN(ALIGN_IN),
  .MAIN_STATE(MAIN_STATE), .MAIN_OUT(MAIN_OUT), .AUX_OUTPUT(AUX_OUTPUT), .AUX_DRIVE(AUX_DRIVE),
  .ALIGN_INPUT_BIAS(ALIGN_INPUT_BIAS), .ALIGN_DELAY_UNIT(ALIGN_DELAY_UNIT));

// [tb/divider_align_pin_mode_control_test.sv]
// Self-checking bench for the clock control block
module divider_align_pin_mode_control_test
  import clk_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_b = 1'b0, we = 1'b0, msel = 1'b0, rlo = 1'b0, rhi = 1'b0, fire = 1'b0, align;
  logic [6:0]  addr = 7'h00;   // Register address
  logic [15:0] wdata = 16'h0000, rdata;
  logic [2:0]  en_pin = 3'h0;  // Enable pins
  logic [3:0]  main_out;       // Main phases
  logic        aux_out;        // Aux phase
  logic [1:0]  bias, unit;     // Alignment codes
  main_state_t st;             // Effective main state
  aux_drive_t  drv;            // Aux driver selection
  int mismatches = 0, checked = 0;
  // Row: en_pin, mode pin, {hi,lo}, mode word, reg enables, aux word, {step,bias}, divider, ratio
  typedef logic [50:0] row_t;
  row_t rows [8] = '{{3'h7, 1'b0, 2'h0, 16'h0001, 4'hF, 16'h0000, 4'h0, 1'b0, 4'h1},
    {3'h3, 1'b0, 2'h0, 16'h0012, 4'hF, 16'h00A2, 4'h5, 1'b1, 4'h3},
    {3'h5, 1'b0, 2'h1, 16'h002A, 4'hA, 16'h0014, 4'hA, 1'b1, 4'h2},
    {3'h1, 1'b0, 2'h2, 16'h002A, 4'h5, 16'h00E2, 4'hF, 1'b1, 4'h3},
    {3'h6, 1'b0, 2'h3, 16'h0012, 4'hF, 16'h001C, 4'h6, 1'b1, 4'h4},
    {3'h7, 1'b1, 2'h0, 16'h0021, 4'h3, 16'h0002, 4'hC, 1'b1, 4'h5},
    {3'h0, 1'b0, 2'h3, 16'h0001, 4'hF, 16'h0000, 4'h3, 1'b0, 4'h1},
    {3'h4, 1'b1, 2'h2, 16'h0001, 4'hE, 16'h00E2, 4'h9, 1'b1, 4'h3}};
  logic [6:0]  ra [5] = '{OUT_CTRL_ADDR, AUX_CFG_ADDR, AUX_POSTDIV_ADDR, ALIGN_CFG_ADDR, 7'h40};
  logic [15:0] rv [5] = '{OUT_CTRL_RST, AUX_CFG_RST, AUX_POSTDIV_RST, ALIGN_CFG_RST, 16'h0000};
  int dpre [6] = '{0, 0, 0, 2, 4, 9};        // Aux {band, prediv} codes
  int dpost [6] = '{1, 3, 4, 1, 1, 1};       // Aux post ratios
  int dhigh [6] = '{24, 8, 12, 12, 12, 12};  // High clocks out of 24
  int dtog [6] = '{0, 16, 12, 12, 24, 12};   // Level changes in 24 clocks
  divider_align_pin_mode_control u_divider_align_pin_mode_control (.SYS_CLK(clk), .RST_B(rst_b),
    .REG_WE(we), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .OUT_ENABLE_PIN(en_pin),
    .MODE_SELECT_PIN(msel), .RATIO_SELECT_PIN_LO(rlo), .RATIO_SELECT_PIN_HI(rhi), .ALIGN_IN(align),
    .MAIN_STATE(st), .MAIN_OUT(main_out), .AUX_OUTPUT(aux_out), .AUX_DRIVE(drv),
    .ALIGN_INPUT_BIAS(bias), .ALIGN_DELAY_UNIT(unit));
  align_pin_driver u_align_pin_driver (.clk(clk), .rst_b(rst_b), .fire(fire), .align_out(align));
  // ----------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // ----------------------------------------------------------------
  initial begin
    forever #4 clk = ~clk;
  end
  // Generous bound; the whole run needs under a thousand clocks
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    wrap_up();
  end
  task automatic wrap_up();
    if (mismatches == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  // Strobe held one full clock, lowered on the taking edge
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk);
    we    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    @(negedge clk);
    d = rdata;
  endtask
  // One alignment pulse; snapshot of all divided phases after the clear
  task automatic align_run(input logic [5:0] taps, output logic [79:0] snap);
    int n;
    wr(ALIGN_CFG_ADDR, {6'h0, taps, 4'h0});
    rd(ALIGN_POS_ADDR, snap[15:0]);
    fire <= 1'b1;
    n = 0;
    while (align !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    repeat (7) @(negedge clk);
    chk({15'h0, rdata[15]}, 16'h0, "position not cleared");
    repeat (taps + 1) @(negedge clk);
    for (int i = 0; i < 16; i++) begin
      snap[i*5 +: 5] = {aux_out, main_out};
      @(negedge clk);
    end
    chk({15'h0, rdata[15]}, 16'h1, "position not valid");
    chk(rdata, 16'h800F, "position value");
    @(posedge clk);
    fire <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] v;
    logic [79:0] s0, s1, s2;
    int hc, tc;
    logic last;
    repeat (6) @(negedge clk);
    chk({7'h0, st}, 16'h0, "state in reset");
    repeat (7) @(posedge clk);
    rst_b <= 1'b1;
    foreach (ra[i]) begin
      rd(ra[i], v);
      chk(v, rv[i], "reset value");
    end
    foreach (rows[i]) begin
      @(posedge clk);
      {en_pin, msel, rhi, rlo} <= rows[i][50:45];
      wr(MAIN_PATH_MODE_DIVIDE_ADDR, rows[i][44:29]);
      wr(OUT_CTRL_ADDR, {12'h0, rows[i][28:25]});
      wr(AUX_CFG_ADDR, rows[i][24:9]);
      wr(ALIGN_CFG_ADDR, {12'h0, rows[i][8:5]});
      repeat (6) @(posedge clk);
      rd(MAIN_PATH_MODE_DIVIDE_ADDR, v);
      chk({11'h0, st.divider_mode, st.ratio}, {11'h0, rows[i][4:0]}, "mode or ratio");
      chk({13'h0, v[2:0]}, {13'h0, rows[i][4] ? MODE_DIVIDER : MODE_BUFFER}, "mode readback");
      chk({12'h0, st.out_en}, {12'h0, {{2{rows[i][50]}}, rows[i][49:48]} & rows[i][28:25]}, "enables");
      chk({14'h0, drv.lvds_sel, drv.cml_sel}, {14'h0, rows[i][10:9] == FMT_LVDS, rows[i][10:9] == FMT_CML}, "fmt");
      chk({13'h0, rows[i][10] ? drv.power_level : drv.common_mode},
        {13'h0, rows[i][10] ? rows[i][16:14] : rows[i][13:11]}, "aux level");
      chk({12'h0, unit, bias}, {12'h0, rows[i][8:5]}, "bias or step");
    end
    @(posedge clk);
    {msel, rhi, rlo} <= 3'h0;
    repeat (8) @(posedge clk);
    for (int c = 1; c < 8; c++) begin
      wr(MAIN_PATH_MODE_DIVIDE_ADDR, 16'((c << DIV_LSB) | MODE_DIVIDER));
      repeat (3) @(posedge clk);
      rd(MAIN_PATH_MODE_DIVIDE_ADDR, v);
      chk({10'h0, v[5:0]}, 16'((c << DIV_LSB) | MODE_DIVIDER), "divide readback");
      chk({12'h0, st.ratio}, 16'(c + 1), "divide ratio");
    end
    foreach (dpre[i]) begin
      wr(AUX_CFG_ADDR, 16'(dpre[i] << 8));
      wr(AUX_POSTDIV_ADDR, 16'(dpost[i]));
      repeat (30) @(negedge clk);
      hc = 0;
      tc = 0;
      last = aux_out;
      repeat (24) begin
        @(negedge clk);
        hc += int'(aux_out);
        tc += int'(aux_out != last);
        last = aux_out;
      end
      chk(16'(hc), 16'(dhigh[i]), "aux duty");
      chk(16'(tc), 16'(dtog[i]), "aux rate");
    end
    @(posedge clk);
    {en_pin, msel, rhi, rlo} <= 6'h3F;
    wr(OUT_CTRL_ADDR, 16'h000F);
    // band 0 with prediv 1 keeps the post input in range
    wr(AUX_CFG_ADDR, 16'h0000);
    wr(AUX_POSTDIV_ADDR, 16'h0006);
    align_run(6'h00, s0);
    align_run(6'h00, s1);
    align_run(6'h05, s2);
    chk({15'h0, s1 === s0}, 16'h1, "phase not repeatable");
    chk({15'h0, s2 === s0}, 16'h1, "delay taps ignored");
    chk(s0[15:0], 16'h43FF, "phase after clear");
    // divider reset bit pulsed high then low
    wr(OUT_CTRL_ADDR, 16'h001F);
    repeat (4) @(negedge clk);
    chk({12'h0, main_out}, 16'h000F, "divider not held");
    repeat (2) @(negedge clk);
    chk({12'h0, main_out}, 16'h000F, "divider not held");
    wr(OUT_CTRL_ADDR, 16'h000F);
    wr(AUX_POSTDIV_ADDR, 16'h03FF);
    rd(AUX_POSTDIV_ADDR, v);
    chk(v, 16'h03FF, "post ratio limit");
    @(posedge clk);
    rst_b <= 1'b0;
    @(negedge clk);
    chk(rdata, AUX_POSTDIV_RST, "second reset");
    chk({7'h0, drv, st.divider_mode}, 16'h0100, "outputs in reset");
    @(posedge clk);
    rst_b <= 1'b1;
    wrap_up();
  end
endmodule
